// file: rtl/edge_capture_timer_8bit.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1 - Eight-bit up-counter steps once per pulse of one of four divided clocks.
// RULE2 - Mode input high gives capture timer; low gives interval timer without capture.
// RULE3 - Falling edge of capture signal copies counter into falling-edge capture register.
// RULE4 - Rising edge of capture signal copies counter into rising-edge capture register.
// RULE5 - Edge select one: falling capture sets request flag; enable gates CPU interrupt.
// RULE6 - Edge select zero: rising capture sets request flag; enable gates CPU interrupt.
// RULE7 - Wrap from ff to 00 with overflow enable sets the request flag.
// RULE8 - In capture mode counter clears on rising, falling, both or no edges.
// RULE9 - Each overflow is recorded as happening with capture input high or low.
// RULE10 - Counter cannot be read or written over the register port.
// RULE11 - Both capture registers are eight bits, read-only; writes do nothing.
// RULE12 - Reset zeroes counter and both capture registers.
// RULE13 - Toggling the mode input may itself produce a capture edge.
// RULE14 - Without filter the source holds each level at least two clock periods.
// RULE15 - With subclock/2 selected the counter keeps running in low-power sub modes.
// RULE16 - Clock select 00 /64, 01 /32, 10 /2, 11 subclock/2; reset picks /64.
// RULE17 - Clear field 00 none, 01 falling, 10 rising, 11 both edges.
// RULE18 - Noise filter: five samples on selected clock; output changes when all agree.
// RULE19 - Overflow high flag when input high, low flag otherwise; software clears only.
// RULE20 - Capture pin synchronised before edge detection; one combined interrupt request out.
module edge_capture_timer_8bit (
  input  wire logic                       mclk,                // System clock, 200 MHz.
  input  wire logic                       resetn,              // Asynchronous reset.
  input  wire edge_capture_pkg::reg_req_t bus_req,             // Register port request.
  output logic [7:0]                      rdata,               // Read data, cycle after read.
  input  wire logic                       capture_pin,         // Asynchronous capture input.
  input  wire logic                       sub_clk,             // Asynchronous subclock.
  input  wire logic                       capture_mode,        // Capture mode bit.
  input  wire logic                       noise_filter_enable, // Filter enable bit.
  input  wire logic                       low_power_sub,       // Subactive or subsleep.
  input  wire logic                       timer_irq_enable,    // Interrupt enable bit.
  input  wire logic                       irq_flag_clear,      // Clears request flag.
  output logic                            timer_irq_flag,      // Request flag.
  output logic                            timer_irq            // Request to controller.
);

  edge_capture_pkg::mode_ctrl_t mode_ctrl;
  logic [7:0]                   count;
  logic [7:0]                   falling_edge_capture;
  logic [7:0]                   rising_edge_capture;
  logic [5:0]                   div_cnt;
  logic [1:0]                   pin_sync;
  logic [2:0]                   sub_sync;
  logic                         sub_half;
  logic [4:0]                   filter_taps;
  logic                         filt_level;
  logic                         cap_prev;
  logic                         cap_level;
  logic                         rise_edge;
  logic                         fall_edge;
  logic                         sub_tick;
  logic                         count_tick;
  logic                         count_clear;
  logic                         overflow;
  logic                         wr_mode;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic clear_hit(input edge_capture_pkg::clear_sel_t sel,
                                     input logic rise, input logic fall);
    clear_hit = ((sel == edge_capture_pkg::CLEAR_RISE) && rise) ||
                ((sel == edge_capture_pkg::CLEAR_FALL) && fall) ||
                ((sel == edge_capture_pkg::CLEAR_BOTH) && (rise || fall));
  endfunction

  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] target);
    addr_is = (a == target);
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Only the second stage is read, so a level that is held two periods is never missed.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_sync <= 2'b00;
    end else begin
      pin_sync <= {pin_sync[0], capture_pin}; // RULE20 RULE14
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sub_sync <= 3'b000;
    end else begin
      sub_sync <= {sub_sync[1:0], sub_clk};
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // The subclock is divided by two by counting every second rising edge.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sub_half <= 1'b0;
    end else if (sub_sync[1] && !sub_sync[2]) begin
      sub_half <= !sub_half;
    end
  end

  assign sub_tick = sub_sync[1] && !sub_sync[2] && sub_half;

  // In the low-power sub modes the system clock divider keeps running but its ticks are masked.
  always_comb begin
    unique case (mode_ctrl.cks) // RULE16
      edge_capture_pkg::CLK_DIV64: begin
        count_tick = !low_power_sub && (div_cnt == edge_capture_pkg::DIV64_MATCH);
      end
      edge_capture_pkg::CLK_DIV32: begin
        count_tick = !low_power_sub && (div_cnt[4:0] == edge_capture_pkg::DIV32_MATCH);
      end
      edge_capture_pkg::CLK_DIV2: begin
        count_tick = !low_power_sub && div_cnt[0];
      end
      edge_capture_pkg::CLK_SUB2: begin
        count_tick = sub_tick; // RULE15
      end
    endcase
  end

  // ****************************************************************
  // Noise filter and edge detection
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      filter_taps <= edge_capture_pkg::FILTER_ALL_ZER;
    end else if (!noise_filter_enable || count_tick) begin
      filter_taps <= {filter_taps[edge_capture_pkg::FILTER_STAGES-2:0], pin_sync[1]}; // RULE18
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      filt_level <= 1'b0;
    end else if (!noise_filter_enable) begin
      filt_level <= pin_sync[1];
    end else if (filter_taps == edge_capture_pkg::FILTER_ALL_ONE) begin
      filt_level <= 1'b1; // RULE18
    end else if (filter_taps == edge_capture_pkg::FILTER_ALL_ZER) begin
      filt_level <= 1'b0;
    end
  end

  // Gating by the mode bit means a mode change can itself look like an edge.
  assign cap_level = capture_mode && filt_level; // RULE2 RULE13

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= cap_level;
    end
  end

  assign rise_edge = cap_level && !cap_prev;
  assign fall_edge = !cap_level && cap_prev;

  // ****************************************************************
  // Counter and captures
  // ****************************************************************
  assign count_clear = capture_mode && clear_hit(mode_ctrl.cclr, rise_edge, fall_edge); // RULE8 RULE17
  assign overflow    = count_tick && !count_clear && (count == edge_capture_pkg::COUNT_MAX);

  // Clearing wins over a step in the same cycle.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= edge_capture_pkg::COUNT_RESET; // RULE12
    end else if (count_clear) begin
      count <= edge_capture_pkg::COUNT_RESET; // RULE8
    end else if (count_tick) begin
      count <= count + 8'h01; // RULE1
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      falling_edge_capture <= edge_capture_pkg::CAPTURE_RESET; // RULE12
    end else if (fall_edge) begin
      falling_edge_capture <= count; // RULE3 RULE11
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rising_edge_capture <= edge_capture_pkg::CAPTURE_RESET; // RULE12
    end else if (rise_edge) begin
      rising_edge_capture <= count; // RULE4 RULE11
    end
  end

  // ****************************************************************
  // Mode control register
  // ****************************************************************
  assign wr_mode = bus_req.wr && addr_is(bus_req.addr, edge_capture_pkg::MODE_CTRL_ADDR);

  // Overflow flags: a write of one is ignored, a write of zero clears, and a set wins.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_ctrl <= edge_capture_pkg::MODE_CTRL_RESET;
    end else begin
      if (wr_mode) begin
        mode_ctrl.overflow_irq_enable  <= bus_req.wdata[5];
        mode_ctrl.irq_edge_select <= bus_req.wdata[4];
        mode_ctrl.cclr  <= edge_capture_pkg::clear_sel_t'(bus_req.wdata[3:2]);
        mode_ctrl.cks   <= edge_capture_pkg::clk_sel_t'(bus_req.wdata[1:0]);
      end
      if (overflow && cap_level) begin
        mode_ctrl.ovf_high <= 1'b1; // RULE9 RULE19
      end else if (wr_mode && !bus_req.wdata[7]) begin
        mode_ctrl.ovf_high <= 1'b0; // RULE19
      end
      if (overflow && !cap_level) begin
        mode_ctrl.ovf_low <= 1'b1; // RULE9 RULE19
      end else if (wr_mode && !bus_req.wdata[6]) begin
        mode_ctrl.ovf_low <= 1'b0; // RULE19
      end
    end
  end

  // The counter has no address; unmapped reads return zero.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= edge_capture_pkg::READ_IDLE;
    end else if (!bus_req.rd) begin
      rdata <= edge_capture_pkg::READ_IDLE;
    end else if (addr_is(bus_req.addr, edge_capture_pkg::MODE_CTRL_ADDR)) begin
      rdata <= mode_ctrl;
    end else if (addr_is(bus_req.addr, edge_capture_pkg::FALL_CAP_ADDR)) begin
      rdata <= falling_edge_capture;
    end else if (addr_is(bus_req.addr, edge_capture_pkg::RISE_CAP_ADDR)) begin
      rdata <= rising_edge_capture;
    end else begin
      rdata <= edge_capture_pkg::READ_IDLE; // RULE10
    end
  end

  // ****************************************************************
  // Interrupt request
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_irq_flag <= 1'b0;
    end else if ((fall_edge && mode_ctrl.irq_edge_select) ||        // RULE5
                 (rise_edge && !mode_ctrl.irq_edge_select) ||       // RULE6
                 (overflow && mode_ctrl.overflow_irq_enable)) begin      // RULE7
      timer_irq_flag <= 1'b1;
    end else if (irq_flag_clear) begin
      timer_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= timer_irq_flag && timer_irq_enable; // RULE20
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  count_step_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
    (count_tick && !count_clear) |=> (count == $past(count) + 8'h01))
    else $error("Counter did not step on its clock pulse.");

  fall_capture_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
    fall_edge |=> (falling_edge_capture == $past(count)))
    else $error("Falling capture missed the counter value.");

  rise_capture_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
    rise_edge |=> (rising_edge_capture == $past(count)))
    else $error("Rising capture missed the counter value.");

  irq_fall_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
    (fall_edge && mode_ctrl.irq_edge_select) |=> timer_irq_flag ##1 (timer_irq == $past(timer_irq_enable)))
    else $error("Falling capture did not raise the request.");

  irq_rise_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
    (rise_edge && !mode_ctrl.irq_edge_select) |=> timer_irq_flag)
    else $error("Rising capture did not raise the request.");

  irq_overflow_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
    (overflow && mode_ctrl.overflow_irq_enable) |=> (timer_irq_flag && count == 8'h00))
    else $error("Overflow did not raise the request.");

  edge_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
    (capture_mode && rise_edge && mode_ctrl.cclr == edge_capture_pkg::CLEAR_RISE)
    |=> (count == 8'h00))
    else $error("Rising edge did not clear the counter.");

  fall_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE17
    (capture_mode && fall_edge && mode_ctrl.cclr == edge_capture_pkg::CLEAR_FALL)
    |=> (count == 8'h00))
    else $error("Falling edge did not clear the counter.");

  ovf_side_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
    overflow |=> (cap_prev ? mode_ctrl.ovf_high : mode_ctrl.ovf_low))
    else $error("Overflow recorded on the wrong side.");

  interval_quiet_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE2
    (!capture_mode && $past(!capture_mode)) |-> !(rise_edge || fall_edge || count_clear))
    else $error("Interval mode produced a capture.");

  capture_ro_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE11
    (bus_req.wr && !fall_edge) |=> $stable(falling_edge_capture))
    else $error("Write changed a capture register.");

  sub_only_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE15
    (low_power_sub && mode_ctrl.cks != edge_capture_pkg::CLK_SUB2) |-> !count_tick)
    else $error("System clock source ran in a sub mode.");

  filter_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // RULE18
    (noise_filter_enable && filter_taps != edge_capture_pkg::FILTER_ALL_ONE &&
     filter_taps != edge_capture_pkg::FILTER_ALL_ZER) |=> $stable(filt_level))
    else $error("Filter output moved without agreement.");

  capture_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
    rise_edge ##[1:600] fall_edge);

  overflow_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
    overflow && mode_ctrl.overflow_irq_enable);

  irq_seen_c: cover property (@(posedge mclk) disable iff (!resetn)
    timer_irq);

  sub_count_c: cover property (@(posedge mclk) disable iff (!resetn)
    low_power_sub && count_tick);

endmodule
`default_nettype wire

// file: rtl/edge_capture_pkg.sv
`default_nettype none
package edge_capture_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] MODE_CTRL_ADDR = 16'hffbc;
  localparam logic [15:0] FALL_CAP_ADDR  = 16'hffbd;
  localparam logic [15:0] RISE_CAP_ADDR  = 16'hffbe;

  // ****************************************************************
  // Reset values and counter maximum
  // ****************************************************************
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] CAPTURE_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET     = 8'h00;
  localparam logic [7:0] COUNT_MAX       = 8'hff;
  localparam logic [7:0] READ_IDLE       = 8'h00;

  // ****************************************************************
  // Prescaler and filter constants
  // ****************************************************************
  localparam logic [5:0] DIV64_MATCH    = 6'h3f;
  localparam logic [4:0] DIV32_MATCH    = 5'h1f;
  localparam int         FILTER_STAGES  = 5;
  localparam logic [4:0] FILTER_ALL_ONE = 5'h1f;
  localparam logic [4:0] FILTER_ALL_ZER = 5'h00;

  typedef enum logic [1:0] {
    CLK_DIV64 = 2'b00,
    CLK_DIV32 = 2'b01,
    CLK_DIV2  = 2'b10,
    CLK_SUB2  = 2'b11
  } clk_sel_t;

  typedef enum logic [1:0] {
    CLEAR_NONE = 2'b00,
    CLEAR_FALL = 2'b01,
    CLEAR_RISE = 2'b10,
    CLEAR_BOTH = 2'b11
  } clear_sel_t;

  typedef struct packed {
    logic       ovf_high;
    logic       ovf_low;
    logic       overflow_irq_enable;
    logic       irq_edge_select;
    clear_sel_t cclr;
    clk_sel_t   cks;
  } mode_ctrl_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage
`default_nettype wire

// file: verification/capture_pulse_source.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// External pulse source on the capture input
// ****************************************************************
module capture_pulse_source (
  input  wire logic        mclk,   // Reference clock.
  input  wire logic        go,     // Starts one pulse.
  input  wire logic [15:0] hi_len, // Cycles held high.
  input  wire logic [15:0] lo_len, // Cycles held low afterwards.
  output logic             pin,    // Capture input level.
  output logic             busy    // High while a pulse runs.
);
  logic [15:0] left;
  logic        phase_hi;

  // A level shorter than two cycles could be missed without the filter, so it is stretched.
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    left = 16'h0000;
    phase_hi = 1'b0;
  end

  always @(posedge mclk) begin
    if (go && !busy) begin
      pin <= 1'b1;
      busy <= 1'b1;
      phase_hi <= 1'b1;
      left <= (hi_len < 16'h0002) ? 16'h0002 : hi_len;
    end else if (busy) begin
      if (left > 16'h0001) begin
        left <= left - 16'h0001;
      end else if (phase_hi) begin
        pin <= 1'b0;
        phase_hi <= 1'b0;
        left <= (lo_len < 16'h0002) ? 16'h0002 : lo_len;
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/edge_capture_timer_8bit_bench.sv
`timescale 1ns/10ps
`default_nettype none

`define check(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, (ex), (got)); end end

module edge_capture_timer_8bit_bench;
  logic                       mclk = 1'b0;
  logic                       resetn = 1'b0;
  logic                       sub_clk = 1'b0;
  logic                       cap_mode = 1'b1;
  logic                       filt_en = 1'b0;
  logic                       low_pwr = 1'b0;
  logic                       irq_en = 1'b0;
  logic                       flag_clr = 1'b0;
  logic                       go = 1'b0;
  logic                       pin;
  logic                       busy;
  logic                       flag;
  logic                       irq;
  logic [7:0]                 rdata;
  logic [7:0]                 v;
  logic [7:0]                 w;
  logic [15:0]                hi = 16'h0002;
  logic [15:0]                lo = 16'h0002;
  edge_capture_pkg::reg_req_t req = '0;
  int                         fails = 0;
  int                         total_checks = 0;
  int                         h;
  int                         l;
  int                         k;
  int                         divs[3] = '{64, 32, 2};

  always #2.5 mclk = ~mclk;
  always #18.5 sub_clk = ~sub_clk;

  edge_capture_timer_8bit edge_capture_timer_8bit_i (.mclk(mclk), .resetn(resetn),
    .bus_req(req), .rdata(rdata), .capture_pin(pin), .sub_clk(sub_clk),
    .capture_mode(cap_mode), .noise_filter_enable(filt_en), .low_power_sub(low_pwr),
    .timer_irq_enable(irq_en), .irq_flag_clear(flag_clr), .timer_irq_flag(flag),
    .timer_irq(irq));
  capture_pulse_source capture_pulse_source_i (.mclk(mclk), .go(go), .hi_len(hi),
    .lo_len(lo), .pin(pin), .busy(busy));

  // ****************************************************************
  // Bus, pulse and verdict helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic start_pulse(input int hl, input int ll);
    @(posedge mclk);
    hi <= 16'(hl);
    lo <= 16'(ll);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  // The low time seen by the timer is the requested one plus 14 cycles of turnaround here.
  task automatic end_pulse;
    int n;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 5000) fails++;
    cyc(12);
  endtask

  task automatic pulse(input int hl, input int ll);
    start_pulse(hl, ll);
    end_pulse();
  endtask

  function automatic logic near(input logic [7:0] got, input int ex, input int tol);
    return !$isunknown(got) && int'(got) >= ex - tol && int'(got) <= ex + tol;
  endfunction

  task automatic conclude;
    $display("Checks made %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    conclude();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(28066));
    cyc(5);
    resetn <= 1'b1;
    for (k = 0; k < 4; k++) begin
      rd(16'hffbc + 16'(k), v);
      `check("reset read", 8'h00, v)
    end
    for (k = 1; k < 4; k++) begin
      wr(16'hffbc + 16'(k), 8'($urandom));
      rd(16'hffbc + 16'(k), v);
      `check("read only", 8'h00, v)
    end
    w = 8'($urandom) | 8'hc0;
    wr(edge_capture_pkg::MODE_CTRL_ADDR, w);
    rd(edge_capture_pkg::MODE_CTRL_ADDR, v);
    `check("mode flags", w & 8'h3f, v)
    for (k = 0; k < 3; k++) begin
      h = divs[k] * (4 + $urandom_range(25));
      wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h08 | 8'(k));
      pulse(h, 20);
      rd(edge_capture_pkg::FALL_CAP_ADDR, v);
      `check("divided count", 1'b1, near(v, h / divs[k], 1))
    end
    h = 8 + $urandom_range(190);
    l = 8 + $urandom_range(190);
    wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h0e);
    pulse(h, l);
    rd(edge_capture_pkg::FALL_CAP_ADDR, v);
    `check("high width", 1'b1, near(v, h / 2, 1))
    pulse(4, 4);
    rd(edge_capture_pkg::RISE_CAP_ADDR, v);
    // The read between the two pulses stretches the low time by two more cycles.
    `check("low width", 1'b1, near(v, (l + 16) / 2, 1))
    for (k = 0; k < 2; k++) begin
      @(posedge mclk);
      irq_en <= ~irq_en;
      flag_clr <= 1'b1;
      wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h06 | 8'(k << 4));
      flag_clr <= 1'b0;
      start_pulse(40, 40);
      cyc(20);
      `check("flag at rise", 1'(k == 0), flag)
      end_pulse();
      `check("flag after fall", 1'b1, flag)
      `check("irq gated", irq_en, irq)
    end
    @(posedge mclk);
    cap_mode <= 1'b0;
    flag_clr <= 1'b1;
    wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h22);
    flag_clr <= 1'b0;
    rd(edge_capture_pkg::FALL_CAP_ADDR, w);
    pulse(30, 30);
    rd(edge_capture_pkg::FALL_CAP_ADDR, v);
    `check("interval capture", w, v)
    cyc(520);
    rd(edge_capture_pkg::MODE_CTRL_ADDR, v);
    `check("low overflow", 8'h62, v)
    `check("overflow flag", 1'b1, flag)
    @(posedge mclk);
    cap_mode <= 1'b1;
    wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h2e);
    pulse(4, 4);
    wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h2e);
    rd(edge_capture_pkg::MODE_CTRL_ADDR, v);
    `check("flag clear", 8'h2e, v)
    pulse(700, 4);
    rd(edge_capture_pkg::MODE_CTRL_ADDR, v);
    `check("high overflow", 8'hae, v)
    // Dropping the mode bit while the pin is high looks like a falling edge.
    start_pulse(200, 4);
    cyc(40);
    @(posedge mclk);
    cap_mode <= 1'b0;
    rd(edge_capture_pkg::FALL_CAP_ADDR, v);
    `check("mode toggle edge", 1'b1, near(v, 19, 1))
    @(posedge mclk);
    cap_mode <= 1'b1;
    end_pulse();
    @(posedge mclk);
    low_pwr <= 1'b1;
    wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h0b);
    h = 200 + $urandom_range(300);
    pulse(h, 20);
    rd(edge_capture_pkg::FALL_CAP_ADDR, v);
    `check("sub count", 1'b1, near(v, h * 5 / 74, 2))
    @(posedge mclk);
    low_pwr <= 1'b0;
    filt_en <= 1'b1;
    wr(edge_capture_pkg::MODE_CTRL_ADDR, 8'h0a);
    cyc(30);
    rd(edge_capture_pkg::FALL_CAP_ADDR, w);
    pulse(6, 40);
    rd(edge_capture_pkg::FALL_CAP_ADDR, v);
    `check("short pulse", w, v)
    h = 2 * (20 + $urandom_range(60));
    pulse(h, 40);
    rd(edge_capture_pkg::FALL_CAP_ADDR, v);
    `check("filtered count", 1'b1, near(v, h / 2, 2))
    conclude();
  end
endmodule
`default_nettype wire
